/* hw/dms_pkg.sv */
// Constants, register map and encodings for the signed DSP datapath unit
package dms_pkg;

  // ------------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] DMS_OFF_OPA    = 8'h00;
  localparam logic [7:0] DMS_OFF_OPB    = 8'h04;
  localparam logic [7:0] DMS_OFF_INSTR  = 8'h08;
  localparam logic [7:0] DMS_OFF_CTRL   = 8'h0c;
  localparam logic [7:0] DMS_OFF_RESULT = 8'h10;
  localparam logic [7:0] DMS_OFF_FLAGS  = 8'h14;
  localparam logic [7:0] DMS_OFF_STATUS = 8'h18;
  localparam logic [7:0] DMS_OFF_MASK   = 8'h1c;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int DMS_CTRL_GO     = 0;
  localparam int DMS_CTRL_COND   = 1;
  localparam int DMS_CTRL_DSP    = 2;
  localparam int DMS_FLAG_Q      = 0;
  localparam int DMS_FLAG_GE_LSB = 4;
  localparam int DMS_ST_DONE     = 0;
  localparam int DMS_ST_SAT      = 1;
  localparam int DMS_ST_UNDEF    = 2;
  localparam int DMS_ST_UNPRED   = 3;
  localparam int DMS_ST_W        = 4;

  // ------------------------------------------------------------------
  // Values after reset
  // ------------------------------------------------------------------
  localparam logic [31:0]         DMS_RST_WORD   = 32'h0000_0000;
  localparam logic [2:0]          DMS_RST_CTRL   = 3'h6;
  localparam logic [3:0]          DMS_RST_GE     = 4'h0;
  localparam logic [DMS_ST_W-1:0] DMS_RST_STATUS = 4'h0;
  localparam logic [DMS_ST_W-1:0] DMS_RST_MASK   = 4'h0;

  // ------------------------------------------------------------------
  // Encoding patterns (first halfword in instr[31:16]; DMS_ENC_HW2HI is matched on instr[15:12])
  // ------------------------------------------------------------------
  localparam logic [11:0] DMS_ENC_MULW  = 12'hfb3;
  localparam logic [11:0] DMS_ENC_MUSD  = 12'hfb4;
  localparam logic [11:0] DMS_ENC_XSA   = 12'hfae;
  localparam logic [11:0] DMS_ENC_SSUB  = 12'hfad;
  localparam logic [9:0]  DMS_ENC_SAT   = 10'h3cc;
  localparam logic [3:0]  DMS_ENC_HW2HI = 4'hf;
  localparam logic [3:0]  DMS_REG_SP    = 4'hd;
  localparam logic [3:0]  DMS_REG_PC    = 4'hf;

  // Decoded operation
  typedef enum logic [2:0] {
    DMS_OP_NONE  = 3'h0,
    DMS_OP_MULW  = 3'h1,
    DMS_OP_MUSD  = 3'h3,
    DMS_OP_SATW  = 3'h2,
    DMS_OP_SAT16 = 3'h6,
    DMS_OP_XSA   = 3'h7,
    DMS_OP_SSUB  = 3'h5
  } dms_op_t;

endpackage

/* hw/dms_unit.sv */
// Signed DSP datapath unit behind an AHB-Lite register slave
`timescale 1ns/1ps

module dms_unit (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             irq
);
  import dms_pkg::*;

  // ------------------------------------------------------------------
  // Bus slave
  // ------------------------------------------------------------------
  logic                dp_wr;
  logic                dp_rd;
  logic [7:0]          dp_addr;
  logic [31:0]         opa;
  logic [31:0]         opb;
  logic [31:0]         instr;
  logic                cond_pass;
  logic                dsp_ext;
  logic                exec;
  logic [31:0]         result;
  logic                q_flag;
  logic [3:0]          ge;
  logic [DMS_ST_W-1:0] status;
  logic [DMS_ST_W-1:0] mask;
  logic                wr_ctrl;
  logic                wr_flags;
  logic                wr_status;

  // Address phase capture; every transfer completes with no wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr   <= 1'b0;
      dp_rd   <= 1'b0;
      dp_addr <= 8'h00;
    end else if (hready) begin
      dp_wr   <= hsel && htrans[1] && hwrite;
      dp_rd   <= hsel && htrans[1] && !hwrite;
      dp_addr <= haddr[7:0];
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;    // Always OKAY
  assign wr_ctrl   = dp_wr && (dp_addr == DMS_OFF_CTRL);
  assign wr_flags  = dp_wr && (dp_addr == DMS_OFF_FLAGS);
  assign wr_status = dp_wr && (dp_addr == DMS_OFF_STATUS);

  // Operand and instruction registers written by software
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      opa   <= DMS_RST_WORD;
      opb   <= DMS_RST_WORD;
      instr <= DMS_RST_WORD;
    end else if (dp_wr) begin
      if (dp_addr == DMS_OFF_OPA)   opa   <= hwdata;
      if (dp_addr == DMS_OFF_OPB)   opb   <= hwdata;
      if (dp_addr == DMS_OFF_INSTR) instr <= hwdata;
    end
  end

  // Control: go launches one execution in the following cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cond_pass <= DMS_RST_CTRL[DMS_CTRL_COND];
      dsp_ext   <= DMS_RST_CTRL[DMS_CTRL_DSP];
      exec      <= DMS_RST_CTRL[DMS_CTRL_GO];
    end else begin
      exec <= wr_ctrl && hwdata[DMS_CTRL_GO];
      if (wr_ctrl) begin
        cond_pass <= hwdata[DMS_CTRL_COND];
        dsp_ext   <= hwdata[DMS_CTRL_DSP];
      end
    end
  end

  // Read data is a mux of flops selected by the registered address
  always_comb begin
    hrdata = 32'h0000_0000;
    if (dp_rd) begin
      case (dp_addr)
        DMS_OFF_OPA:    hrdata = opa;
        DMS_OFF_OPB:    hrdata = opb;
        DMS_OFF_INSTR:  hrdata = instr;
        DMS_OFF_CTRL:   hrdata = {29'h0, dsp_ext, cond_pass, 1'b0};
        DMS_OFF_RESULT: hrdata = result;
        DMS_OFF_FLAGS:  hrdata = {24'h0, ge, 3'h0, q_flag};
        DMS_OFF_STATUS: hrdata = {28'h0, status};
        DMS_OFF_MASK:   hrdata = {28'h0, mask};
        default:        hrdata = 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------------
  logic [15:0] hw1;
  logic [15:0] hw2;
  logic [3:0]  rd_f;
  logic [3:0]  first_src_reg_field;
  logic [3:0]  second_src_reg_field;
  logic        shift_type_bit;
  logic [4:0]  imm5;
  logic        sat_family;
  logic        dual_hw2;
  logic        half_bit;
  dms_op_t     op;
  logic        undef;
  logic        unpred;
  logic        commit;

  assign hw1                  = instr[31:16];
  assign hw2                  = instr[15:0];
  assign rd_f                 = hw2[11:8];
  assign first_src_reg_field  = hw1[3:0];
  assign second_src_reg_field = hw2[3:0];
  assign shift_type_bit       = hw1[5];
  assign imm5                 = {hw2[14:12], hw2[7:6]};
  assign half_bit             = hw2[4];
  assign sat_family = (hw1[15:6] == DMS_ENC_SAT) && !hw1[4] && !hw2[15] && !hw2[5];
  assign dual_hw2   = (hw2[15:12] == DMS_ENC_HW2HI) && (hw2[7:5] == 3'h0);

  // Pattern match; the dual saturate hides inside the word saturate space
  always_comb begin
    op = DMS_OP_NONE;
    if (hw1[15:4] == DMS_ENC_MULW && dual_hw2) begin
      op = DMS_OP_MULW;
    end else if (hw1[15:4] == DMS_ENC_MUSD && dual_hw2) begin
      op = DMS_OP_MUSD;
    end else if (hw1[15:4] == DMS_ENC_XSA && dual_hw2 && !half_bit) begin
      op = DMS_OP_XSA;
    end else if (hw1[15:4] == DMS_ENC_SSUB && dual_hw2 && !half_bit) begin
      op = DMS_OP_SSUB;
    end else if (sat_family && shift_type_bit && imm5 == 5'h00) begin
      if (dsp_ext && !hw2[4]) op = DMS_OP_SAT16;
    end else if (sat_family) begin
      op = DMS_OP_SATW;
    end
  end

  function automatic logic bad_reg(input logic [3:0] r);
    bad_reg = (r == DMS_REG_SP) || (r == DMS_REG_PC);
  endfunction

  // Saturates only check destination and source; the other decoded operations check all three, undecoded ones none
  always_comb begin
    case (op)
      DMS_OP_SATW, DMS_OP_SAT16:
        unpred = bad_reg(rd_f) || bad_reg(first_src_reg_field);
      DMS_OP_NONE:
        unpred = 1'b0;
      default:
        unpred = bad_reg(rd_f) || bad_reg(first_src_reg_field) ||
                 bad_reg(second_src_reg_field);
    endcase
  end

  assign undef  = (op == DMS_OP_NONE);
  // Unpredictable forms are refused rather than executed
  assign commit = exec && cond_pass && !undef && !unpred;

  // ------------------------------------------------------------------
  // Datapath
  // ------------------------------------------------------------------
  logic signed [15:0] opb_half;
  logic signed [47:0] mulw_prod;
  logic        [31:0] opb_rot;
  logic signed [31:0] prod_lo;
  logic signed [31:0] prod_hi;
  logic signed [32:0] musd_diff;
  logic        [31:0] shifted;
  logic        [32:0] sat_word;
  logic        [32:0] sat_lo;
  logic        [32:0] sat_hi;
  logic        [16:0] xsa_sum;
  logic        [16:0] xsa_diff;
  logic        [16:0] sub_lo;
  logic        [16:0] sub_hi;
  logic        [31:0] next_result;
  logic               next_sat;
  logic        [3:0]  next_ge;
  logic               ge_write;

  // Clamp v to n signed bits; top bit of the answer says it clamped
  function automatic logic [32:0] dms_sat(input logic [31:0] v, input logic [5:0] n);
    logic signed [63:0] hi;
    logic signed [63:0] lo;
    logic signed [63:0] x;
    hi = (64'sh1 <<< (n - 6'h1)) - 64'sh1;
    lo = -hi - 64'sh1;
    x  = {{32{v[31]}}, v};
    if (x > hi)      dms_sat = {1'b1, hi[31:0]};
    else if (x < lo) dms_sat = {1'b1, lo[31:0]};
    else             dms_sat = {1'b0, v};
  endfunction

  assign opb_half  = half_bit ? opb[31:16] : opb[15:0];
  assign mulw_prod = $signed(opa) * opb_half;
  assign opb_rot   = half_bit ? {opb[15:0], opb[31:16]} : opb;
  assign prod_lo   = $signed(opa[15:0]) * $signed(opb_rot[15:0]);
  assign prod_hi   = $signed(opa[31:16]) * $signed(opb_rot[31:16]);
  assign musd_diff = {prod_lo[31], prod_lo} - {prod_hi[31], prod_hi};

  // ASR by zero never reaches here: that encoding is the dual saturate
  assign shifted = shift_type_bit ? 32'($signed(opa) >>> imm5) : (opa << imm5);
  assign sat_word = dms_sat(shifted, {1'b0, hw2[4:0]} + 6'h1);
  assign sat_lo = dms_sat({{16{opa[15]}}, opa[15:0]}, {2'h0, hw2[3:0]} + 6'h1);
  assign sat_hi = dms_sat({{16{opa[31]}}, opa[31:16]}, {2'h0, hw2[3:0]} + 6'h1);

  assign xsa_sum   = {opa[15], opa[15:0]} + {opb[31], opb[31:16]};
  assign xsa_diff  = {opa[31], opa[31:16]} - {opb[15], opb[15:0]};
  assign sub_lo    = {opa[15], opa[15:0]} - {opb[15], opb[15:0]};
  assign sub_hi    = {opa[31], opa[31:16]} - {opb[31], opb[31:16]};

  // Result and flag selection per operation
  always_comb begin
    next_result = result;
    next_sat    = 1'b0;
    next_ge     = ge;
    ge_write    = 1'b0;
    case (op)
      DMS_OP_MULW: next_result = mulw_prod[47:16];
      DMS_OP_MUSD: next_result = musd_diff[31:0];
      DMS_OP_SATW: begin
        next_result = sat_word[31:0];
        next_sat    = sat_word[32];
      end
      DMS_OP_SAT16: begin
        next_result = {sat_hi[15:0], sat_lo[15:0]};
        next_sat    = sat_lo[32] || sat_hi[32];
      end
      DMS_OP_XSA: begin
        next_result = {xsa_diff[15:0], xsa_sum[15:0]};
        next_ge     = {{2{~xsa_diff[16]}}, {2{~xsa_sum[16]}}};
        ge_write    = 1'b1;
      end
      DMS_OP_SSUB: begin
        next_result = {sub_hi[15:0], sub_lo[15:0]};
        next_ge     = {{2{~sub_hi[16]}}, {2{~sub_lo[16]}}};
        ge_write    = 1'b1;
      end
      default: next_result = result;
    endcase
  end

  // Destination register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result <= DMS_RST_WORD;
    end else if (commit) begin
      result <= next_result;
    end
  end

  // Lane flags follow only the add/subtract lanes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ge <= DMS_RST_GE;
    end else if (commit && ge_write) begin
      ge <= next_ge;
    end
  end

  // Sticky saturation flag: a set in the clearing cycle wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q_flag <= 1'b0;
    end else if (commit && next_sat) begin
      q_flag <= 1'b1;
    end else if (wr_flags && hwdata[DMS_FLAG_Q]) begin
      q_flag <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Interrupts
  // ------------------------------------------------------------------
  logic [DMS_ST_W-1:0] ev;

  always_comb begin
    ev                = '0;
    ev[DMS_ST_DONE]   = exec;
    ev[DMS_ST_SAT]    = commit && next_sat;
    ev[DMS_ST_UNDEF]  = exec && cond_pass && undef;
    ev[DMS_ST_UNPRED] = exec && cond_pass && unpred;
  end

  // Write-one-to-clear; a new event in the same cycle keeps its bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status <= DMS_RST_STATUS;
    end else begin
      status <= (status & ~(wr_status ? hwdata[DMS_ST_W-1:0] : '0)) | ev;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask <= DMS_RST_MASK;
    end else if (dp_wr && dp_addr == DMS_OFF_MASK) begin
      mask <= hwdata[DMS_ST_W-1:0];
    end
  end

  assign irq = |(status & mask);

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking dms_cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  logic signed [15:0] chk_half;
  logic signed [47:0] chk_prod;
  assign chk_half = hw2[4] ? $signed(opb[31:16]) : $signed(opb[15:0]);
  assign chk_prod = $signed(opa) * chk_half;

  a_mulw_top_word: assert property (commit && op == DMS_OP_MULW |=>
      result == $past(chk_prod[47:16]))
    else $error("word by half product bits wrong");

  a_mulw_q_kept: assert property (commit && op == DMS_OP_MULW && !wr_flags |=>
      q_flag == $past(q_flag))
    else $error("saturation flag moved on multiply");

  a_musd_q_kept: assert property (commit && op == DMS_OP_MUSD && !wr_flags |=>
      q_flag == $past(q_flag) && $stable(ge))
    else $error("flags moved on dual multiply subtract");

  a_satw_in_range: assert property (commit && op == DMS_OP_SATW && hw2[4:0] == 5'h07 |=>
      ($signed(result) <= 32'sd127) && ($signed(result) >= -32'sd128))
    else $error("word saturate left eight bit range");

  a_satw_sets_q: assert property (commit && op == DMS_OP_SATW && sat_word[32] |=>
      q_flag ##1 q_flag || $past(wr_flags, 1))
    else $error("clamp did not set saturation flag");

  a_sat16_sets_q: assert property (commit && op == DMS_OP_SAT16 &&
      (sat_lo[32] || sat_hi[32]) |=> q_flag && status[DMS_ST_SAT])
    else $error("dual saturate clamp not flagged");

  a_ssub_lanes: assert property (commit && op == DMS_OP_SSUB |=>
      ge[1] == ge[0] && ge[3] == ge[2] &&
      ge[0] == ($signed($past(opa[15:0])) >= $signed($past(opb[15:0]))))
    else $error("subtract lane flags wrong");

  a_xsa_lanes: assert property (commit && op == DMS_OP_XSA |=>
      ge[3:2] == {2{$signed($past(opa[31:16])) >= $signed($past(opb[15:0]))}})
    else $error("exchange lane flags wrong");

  a_cond_fail_hold: assert property (exec && !cond_pass |=>
      $stable(result) && $stable(ge) && (!status[DMS_ST_SAT] || $past(status[DMS_ST_SAT])))
    else $error("failed condition changed state");

  a_sat16_no_ext: assert property (exec && cond_pass && sat_family && shift_type_bit &&
      imm5 == 5'h00 && !dsp_ext |=> $stable(result) && status[DMS_ST_UNDEF])
    else $error("dual saturate ran without extension");

endmodule

/* test/dms_ahb_master.sv */
// AHB-Lite master model standing in for the processor side of the unit
`timescale 1ns/1ps

module dms_ahb_master (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata,
  output logic             timed_out
);
  logic        rdy_q;
  logic [31:0] rdata_q;

  // ------------------------------------------------------------------
  // Edge samples
  // ------------------------------------------------------------------
  // Latch the answer at the edge itself so reading never races the slave
  always @(posedge hclk) begin
    rdy_q   <= hready;
    rdata_q <= hrdata;
  end

  initial begin
    hsel      = 1'b0;
    haddr     = 32'h0;
    htrans    = 2'h0;
    hwrite    = 1'b0;
    hsize     = 3'h2;
    hwdata    = 32'h0;
    timed_out = 1'b0;
  end

  // ------------------------------------------------------------------
  // Transfers
  // ------------------------------------------------------------------
  // Wait for hready high at an edge; the bound cuts a hung slave short
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      #1;
      n++;
    end while (rdy_q !== 1'b1 && n < 64);
    if (rdy_q !== 1'b1) timed_out = 1'b1;
  endtask

  // Single word transfer; released lines show inverted values, not the last ones
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata);
    hsel   <= 1'b1;
    haddr  <= {24'h0, addr};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= 3'h2;
    wait_ready();
    hsel   <= 1'b0;
    haddr  <= ~{24'h0, addr};
    htrans <= 2'h0;
    hwrite <= ~wr;
    hwdata <= wdata;
    wait_ready();
    rdata = rdata_q;
    hwdata <= ~wdata;
  endtask
endmodule

/* test/test_dsp_mul_sat_simd_sub_unit.sv */
// Self-checking bench for the signed DSP datapath unit over its register bus
`timescale 1ns/1ps

module test_dsp_mul_sat_simd_sub_unit;
  import dms_pkg::*;

  // ------------------------------------------------------------------
  // Bus and bookkeeping
  // ------------------------------------------------------------------
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        irq;
  logic        timed_out;
  logic [31:0] rd;
  logic [3:0]  ge;
  logic        q;
  int          error_cnt;
  int          tests_run;

  dms_unit dut_u (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hreadyout),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .irq       (irq)
  );

  dms_ahb_master mst_u (
    .hclk      (hclk),
    .hready    (hreadyout),
    .hrdata    (hrdata),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .timed_out (timed_out)
  );

  // Free-running clock, 8 ns period
  initial hclk = 1'b0;
  always #4 hclk = ~hclk;

  // A hung transfer ends the run at once
  always @(posedge hclk) begin
    if (timed_out === 1'b1) conclude();
  end

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic conclude();
    if (timed_out === 1'b1) error_cnt++;
    $display("checks run %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    mst_u.xfer(1'b0, a, 32'h0, rd);
    check(rd, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    mst_u.xfer(1'b1, a, d, rd);
  endtask

  task automatic flags_chk();
    rd_chk(DMS_OFF_FLAGS, {24'h0, ge, 3'h0, q});
  endtask

  // Load operands and encoding, then launch with the given control bits
  task automatic run(input logic [31:0] ins, input logic [31:0] a, input logic [31:0] b,
                     input logic [2:0] ctl);
    wr(DMS_OFF_OPA, a);
    wr(DMS_OFF_OPB, b);
    wr(DMS_OFF_INSTR, ins);
    wr(DMS_OFF_CTRL, {29'h0, ctl});
  endtask

  // Three-register form: first source 1, destination 2, second source 3
  function automatic logic [31:0] enc3(input logic [11:0] op, input logic m);
    return {op, 4'h1, 4'hf, 4'h2, 3'h0, m, 4'h3};
  endfunction

  function automatic logic [31:0] enc_sat(input logic asr, input logic [4:0] amt,
                                          input logic [4:0] sat);
    return {DMS_ENC_SAT, asr, 1'b0, 4'h1, 1'b0, amt[4:2], 4'h2, amt[1:0], 1'b0, sat};
  endfunction

  // Clamp to a signed range of the given width; bit 32 says it clamped
  function automatic logic [32:0] clamp(input longint v, input int bits);
    longint hi;
    longint lo;
    hi = (longint'(1) <<< (bits - 1)) - 1;
    lo = -hi - 1;
    if (v > hi) return {1'b1, hi[31:0]};
    if (v < lo) return {1'b1, lo[31:0]};
    return {1'b0, v[31:0]};
  endfunction

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] b2;
    logic [31:0] ins;
    logic [32:0] c;
    logic [32:0] c2;
    logic [4:0]  k;
    logic [42:0] st [4];
    longint      p;
    int          s;
    int          d;
    hresetn = 1'b0;
    error_cnt = 0;
    tests_run = 0;
    ge = 4'h0;
    q = 1'b0;
    // Table of {shift type, amount, field, operand}
    st = '{{1'b0, 5'd4, 5'd7, 32'h10}, {1'b1, 5'd31, 5'd0, 32'h8000_0000},
           {1'b0, 5'd0, 5'd31, 32'h8000_0000}, {1'b1, 5'd1, 5'd3, 32'hffff_ff00}};
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values, read-only result and an unmapped word
    wr(DMS_OFF_RESULT, 32'hffff_ffff);
    wr(8'h20, 32'hffff_ffff);
    for (int i = 0; i < 9; i++) begin
      rd_chk(8'(i * 4), (i == 3) ? 32'h6 : 32'h0);
    end
    // Word saturate with shifts; the sticky flag builds up
    for (int i = 0; i < 4; i++) begin
      a = st[i][31:0];
      if (st[i][42]) s = $signed(a) >>> st[i][41:37];
      else s = a << st[i][41:37];
      c = clamp(longint'(s), int'(st[i][36:32]) + 1);
      wr(DMS_OFF_STATUS, 32'hf);
      run(enc_sat(st[i][42], st[i][41:37], st[i][36:32]), a, 32'h0, 3'h7);
      q = q | c[32];
      rd_chk(DMS_OFF_RESULT, c[31:0]);
      flags_chk();
      rd_chk(DMS_OFF_STATUS, {30'h0, c[32], 1'b1});
    end
    // Multiplies with both half selects leave the set flag alone
    a = 32'h8000_8001;
    b = 32'h7fff_8000;
    for (int m = 0; m < 2; m++) begin
      p = longint'($signed(a)) * longint'($signed(m ? b[31:16] : b[15:0]));
      run(enc3(DMS_ENC_MULW, m[0]), a, b, 3'h7);
      rd_chk(DMS_OFF_RESULT, p[47:16]);
      flags_chk();
      b2 = m ? {b[15:0], b[31:16]} : b;
      s = $signed(a[15:0]) * $signed(b2[15:0]);
      d = $signed(a[31:16]) * $signed(b2[31:16]);
      run(enc3(DMS_ENC_MUSD, m[0]), a, b, 3'h7);
      rd_chk(DMS_OFF_RESULT, 32'(s - d));
      flags_chk();
    end
    wr(DMS_OFF_FLAGS, 32'h1);
    q = 1'b0;
    flags_chk();
    // Dual saturate: wide field passes, narrow field clamps the high half only
    for (int i = 0; i < 2; i++) begin
      a = i ? 32'h7fff_0005 : 32'h8000_7fff;
      k = i ? 5'd3 : 5'd15;
      c = clamp(longint'($signed(a[15:0])), k + 1);
      c2 = clamp(longint'($signed(a[31:16])), k + 1);
      run(enc_sat(1'b1, 5'd0, k), a, 32'h0, 3'h7);
      q = q | c[32] | c2[32];
      rd_chk(DMS_OFF_RESULT, {c2[15:0], c[15:0]});
      flags_chk();
    end
    // Without the extension the same encoding is refused
    wr(DMS_OFF_STATUS, 32'hf);
    run(enc_sat(1'b1, 5'd0, 5'd3), 32'h1234_7fff, 32'h0, 3'h3);
    rd_chk(DMS_OFF_RESULT, {c2[15:0], c[15:0]});
    rd_chk(DMS_OFF_STATUS, 32'h5);
    // Exchange subtract-add then dual subtract, zero and overflow lanes
    for (int i = 0; i < 4; i++) begin
      a = i[0] ? 32'h0001_fffe : 32'h7fff_8000;
      b = i[0] ? 32'h0002_0001 : 32'h8000_0001;
      if (i < 2) begin
        s = int'($signed(a[15:0])) + int'($signed(b[31:16]));
        d = int'($signed(a[31:16])) - int'($signed(b[15:0]));
      end else begin
        s = int'($signed(a[15:0])) - int'($signed(b[15:0]));
        d = int'($signed(a[31:16])) - int'($signed(b[31:16]));
      end
      ge = {{2{d >= 0}}, {2{s >= 0}}};
      run(enc3((i < 2) ? DMS_ENC_XSA : DMS_ENC_SSUB, 1'b0), a, b, 3'h7);
      rd_chk(DMS_OFF_RESULT, {d[15:0], s[15:0]});
      flags_chk();
    end
    // Destination field 13 is not executed
    ins = enc3(DMS_ENC_MULW, 1'b0);
    ins[11:8] = 4'hd;
    wr(DMS_OFF_STATUS, 32'hf);
    run(ins, 32'h7fff_ffff, 32'h7fff_7fff, 3'h7);
    rd_chk(DMS_OFF_RESULT, {d[15:0], s[15:0]});
    rd_chk(DMS_OFF_STATUS, 32'h9);
    // Failed condition changes nothing but the done bit
    wr(DMS_OFF_STATUS, 32'hf);
    run(enc3(DMS_ENC_SSUB, 1'b0), 32'h0005_0005, 32'h0, 3'h5);
    rd_chk(DMS_OFF_RESULT, {d[15:0], s[15:0]});
    flags_chk();
    rd_chk(DMS_OFF_STATUS, 32'h1);
    // Interrupt: raise on done, mask it, unmask it, clear it
    wr(DMS_OFF_MASK, 32'h1);
    rd_chk(DMS_OFF_MASK, 32'h1);
    check({31'h0, irq}, 32'h1);
    wr(DMS_OFF_STATUS, 32'hf);
    check({31'h0, irq}, 32'h0);
    run(enc3(DMS_ENC_MULW, 1'b1), 32'h1, 32'h1, 3'h7);
    rd_chk(DMS_OFF_STATUS, 32'h1);
    check({31'h0, irq}, 32'h1);
    wr(DMS_OFF_MASK, 32'h0);
    check({31'h0, irq}, 32'h0);
    wr(DMS_OFF_MASK, 32'h1);
    check({31'h0, irq}, 32'h1);
    wr(DMS_OFF_STATUS, 32'h1);
    check({31'h0, irq}, 32'h0);
    rd_chk(DMS_OFF_STATUS, 32'h0);
    // The slave never signals an error response
    check({31'h0, hresp}, 32'h0);
    conclude();
  end
endmodule
